//--- core/ccde_pkg.sv
// ==========================================================
// Shared constants for the subroutine, clear and decrement group
// ==========================================================
package ccde_pkg;

  // ========================================================
  // Widths
  // ========================================================
  localparam int PC_W = 15;       // Program counter width
  localparam int ACC_W = 8;       // Accumulator and file data width
  localparam int LIT_W = 11;      // Immediate call operand width
  localparam int FADDR_W = 7;     // File register address width
  localparam int LATCH_W = 7;     // Upper-PC latch width
  localparam int OP_W = 4;        // Decoded operation code width
  localparam int GUARD_W = 8;     // Guard timer count width

  // ========================================================
  // Field positions
  // ========================================================
  localparam int IMM_LATCH_HI = 6;  // Latch bits used by immediate call
  localparam int IMM_LATCH_LO = 3;
  localparam int ACC_LATCH_HI = 6;  // Latch bits used by accumulator call

  // ========================================================
  // Reset and fixed values
  // ========================================================
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_STEP = 15'h0002;
  localparam logic [ACC_W-1:0] ACC_RESET = 8'h00;
  localparam logic [ACC_W-1:0] CLEAR_VALUE = 8'h00;
  localparam logic [ACC_W-1:0] DEC_STEP = 8'h01;
  localparam logic [GUARD_W-1:0] GUARD_CLEAR = 8'h00;
  localparam logic [GUARD_W-1:0] GUARD_LAST = 8'hFF;
  localparam logic NULL_RESET = 1'b0;
  localparam logic FLAG_N_RESET = 1'b1;   // Active-low flags idle high

  // ========================================================
  // Timing counts
  // ========================================================
  localparam int ICYC_CLKS_DEF = 4;       // Core clocks per instruction
  localparam int GUARD_PRESC_DEF = 16;    // Core clocks per guard tick

  // ========================================================
  // Decoded operations presented by the fetch stage
  // ========================================================
  typedef enum logic [OP_W-1:0] {
    OP_NOP        = 4'h0,
    OP_CALL_IMM   = 4'h1,
    OP_CALL_ACC   = 4'h2,
    OP_GUARD      = 4'h3,
    OP_COMPLEMENT = 4'h4,
    OP_CLEAR_FILE = 4'h5,
    OP_CLEAR_ACC  = 4'h6,
    OP_DECREMENT  = 4'h7,
    OP_DEC_SKIP   = 4'h8
  } ccde_op_t;

  // Execution states, one-hot
  typedef enum logic [1:0] {
    ST_RUN     = 2'b01,
    ST_DISCARD = 2'b10
  } ccde_state_t;

endpackage

//--- core/ccde_alu.sv
`timescale 1ns/1ns
// ==========================================================
// Result path for the single-operand file operations
// ==========================================================
module ccde_alu (
  input logic [3:0] op_code,
  input logic [7:0] file_val,
  output logic [7:0] result,
  output logic result_zero
);

  // Pure combinational, so the main module can register it
  always_comb begin
    case (op_code)
      ccde_pkg::OP_COMPLEMENT: result = ~file_val;
      ccde_pkg::OP_DECREMENT: result = file_val - ccde_pkg::DEC_STEP;
      ccde_pkg::OP_DEC_SKIP: result = file_val - ccde_pkg::DEC_STEP;
      ccde_pkg::OP_CLEAR_FILE: result = ccde_pkg::CLEAR_VALUE;
      ccde_pkg::OP_CLEAR_ACC: result = ccde_pkg::CLEAR_VALUE;
      default: result = file_val;
    endcase
  end

  // Zero detect drives both the null flag and the skip
  assign result_zero = (result == ccde_pkg::CLEAR_VALUE);

endmodule

//--- core/ccde_exec.sv
`timescale 1ns/1ns
module ccde_exec #(
  parameter int ICYC_CLKS = ccde_pkg::ICYC_CLKS_DEF,
  parameter int GUARD_PRESC = ccde_pkg::GUARD_PRESC_DEF
) (
  input logic core_clk,
  input logic reset,
  input logic op_valid,
  input logic [3:0] op_code,
  input logic [10:0] op_lit,
  input logic [6:0] op_file,
  input logic op_dest,
  input logic [7:0] file_rd_data,
  input logic [6:0] upper_pc_latch,
  input logic sleep_enter,
  output logic [14:0] pc,
  output logic stack_push,
  output logic [14:0] stack_top,
  output logic [7:0] acc,
  output logic null_flag,
  output logic file_wr_en,
  output logic [6:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic discard,
  output logic expiry_flag_n,
  output logic sleep_flag_n,
  output logic [7:0] guard_timer_count,
  output logic icyc_en
);

  // ========================================================
  // Elaboration checks
  // ========================================================
  // A divider of one would leave no room for the fetch stage
  if (ICYC_CLKS < 2) begin : g_bad_icyc
    $error("ICYC_CLKS must be at least 2");
  end
  if (GUARD_PRESC < 2) begin : g_bad_presc
    $error("GUARD_PRESC must be at least 2");
  end

  localparam int DIV_W = $clog2(ICYC_CLKS);
  localparam int PRE_W = $clog2(GUARD_PRESC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(ICYC_CLKS - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(GUARD_PRESC - 1);
  localparam logic [PRE_W-1:0] PRE_ZERO = '0;

  // ========================================================
  // State and registers
  // ========================================================
  logic [DIV_W-1:0] div_reg;          // Core clocks into the cycle
  logic icyc_en_reg;                  // One pulse per instruction
  ccde_pkg::ccde_state_t state_reg;   // Run or discard
  logic [14:0] pc_reg;                // Address of current op
  logic push_reg;                     // Stack push strobe
  logic [14:0] push_data_reg;         // Return address
  logic [7:0] acc_reg;                // Accumulator
  logic null_reg;                     // Null-result flag
  logic wr_en_reg;                    // File write strobe
  logic [6:0] wr_addr_reg;            // File write address
  logic [7:0] wr_data_reg;            // File write data
  logic expiry_n_reg;                 // Active-low expiry flag
  logic sleep_n_reg;                  // Active-low sleep flag
  logic [PRE_W-1:0] presc_reg;        // Guard prescaler
  logic [7:0] guard_reg;              // Guard count

  // Decode helpers
  logic take;          // An op is accepted this core clock
  logic is_call_imm;
  logic is_call_acc;
  logic is_guard;
  logic is_fileop;     // Complement, decrement, decrement-skip
  logic to_file;       // Result goes back to the file register
  logic to_acc;        // Result goes to the accumulator
  logic skip_now;      // Decrement-skip reached zero
  logic [7:0] alu_result;
  logic alu_zero;

  // ========================================================
  // Result path
  // ========================================================
  ccde_alu u_alu (
    .op_code(op_code),
    .file_val(file_rd_data),
    .result(alu_result),
    .result_zero(alu_zero)
  );

  // Ops are only accepted on the cycle pulse while running;
  // during discard the presented op is dropped as a no-op
  assign take = icyc_en_reg && (state_reg == ccde_pkg::ST_RUN) &&
                op_valid;
  assign is_call_imm = take && (op_code == ccde_pkg::OP_CALL_IMM);
  assign is_call_acc = take && (op_code == ccde_pkg::OP_CALL_ACC);
  assign is_guard = take && (op_code == ccde_pkg::OP_GUARD);
  assign is_fileop = (op_code == ccde_pkg::OP_COMPLEMENT) ||
                     (op_code == ccde_pkg::OP_DECREMENT) ||
                     (op_code == ccde_pkg::OP_DEC_SKIP);
  // Destination select for single-operand ops
  assign to_file = take && ((is_fileop && op_dest) ||
                   (op_code == ccde_pkg::OP_CLEAR_FILE));
  assign to_acc = take && ((is_fileop && !op_dest) ||
                  (op_code == ccde_pkg::OP_CLEAR_ACC));
  assign skip_now = take && (op_code == ccde_pkg::OP_DEC_SKIP) &&
                    alu_zero;

  // ========================================================
  // Instruction cycle divider
  // ========================================================
  // One enable pulse every ICYC_CLKS core clocks
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_reg <= DIV_ZERO;
      icyc_en_reg <= 1'b0;
    end else if (div_reg == DIV_LAST) begin
      div_reg <= DIV_ZERO;
      icyc_en_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
      icyc_en_reg <= 1'b0;
    end
  end

  // ========================================================
  // Execution state
  // ========================================================
  // Calls and a taken skip spend one extra cycle discarding
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ccde_pkg::ST_RUN;
    end else begin
      case (state_reg)
        ccde_pkg::ST_RUN: begin
          if (is_call_imm || is_call_acc || skip_now) begin
            state_reg <= ccde_pkg::ST_DISCARD;
          end
        end
        ccde_pkg::ST_DISCARD: begin
          // Second cycle executes as a no-op, then run again
          if (icyc_en_reg) begin
            state_reg <= ccde_pkg::ST_RUN;
          end
        end
        default: state_reg <= ccde_pkg::ST_RUN;
      endcase
    end
  end

  // ========================================================
  // Program counter
  // ========================================================
  // Held during the discard cycle; the target is already loaded
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pc_reg <= ccde_pkg::PC_RESET;
    end else if (is_call_imm) begin
      pc_reg <= {upper_pc_latch[ccde_pkg::IMM_LATCH_HI:
                                ccde_pkg::IMM_LATCH_LO],
                 op_lit};
    end else if (is_call_acc) begin
      pc_reg <= {upper_pc_latch[ccde_pkg::ACC_LATCH_HI:0],
                 acc_reg};
    end else if (skip_now) begin
      // Step over the discarded instruction
      pc_reg <= pc_reg + ccde_pkg::PC_SKIP_STEP;
    end else if (take) begin
      pc_reg <= pc_reg + ccde_pkg::PC_STEP;
    end
  end

  // ========================================================
  // Return stack push
  // ========================================================
  // Push strobe lasts one core clock, data stands until next push
  always_ff @(posedge core_clk) begin
    if (reset) begin
      push_reg <= 1'b0;
      push_data_reg <= ccde_pkg::PC_RESET;
    end else if (is_call_imm || is_call_acc) begin
      push_reg <= 1'b1;
      push_data_reg <= pc_reg + ccde_pkg::PC_STEP;
    end else begin
      push_reg <= 1'b0;
    end
  end

  // ========================================================
  // Accumulator
  // ========================================================
  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_reg <= ccde_pkg::ACC_RESET;
    end else if (to_acc) begin
      // Clear, complement or decrement result
      acc_reg <= alu_result;
    end
  end

  // ========================================================
  // File register write port
  // ========================================================
  // Write strobe is one core clock wide
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 7'h00;
      wr_data_reg <= ccde_pkg::CLEAR_VALUE;
    end else if (to_file) begin
      wr_en_reg <= 1'b1;
      wr_addr_reg <= op_file;
      wr_data_reg <= alu_result;
    end else begin
      wr_en_reg <= 1'b0;
    end
  end

  // ========================================================
  // Null-result flag
  // ========================================================
  // Decrement-skip, calls and guard restart leave it alone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      null_reg <= ccde_pkg::NULL_RESET;
    end else if (take) begin
      case (op_code)
        ccde_pkg::OP_CLEAR_FILE: null_reg <= 1'b1;
        ccde_pkg::OP_CLEAR_ACC: null_reg <= 1'b1;
        ccde_pkg::OP_COMPLEMENT: null_reg <= alu_zero;
        ccde_pkg::OP_DECREMENT: null_reg <= alu_zero;
        default: null_reg <= null_reg;
      endcase
    end
  end

  // ========================================================
  // Guard timer
  // ========================================================
  // Restart wins over a tick in the same clock, so a timely
  // restart can never be overtaken by an expiry
  always_ff @(posedge core_clk) begin
    if (reset || is_guard) begin
      presc_reg <= PRE_ZERO;
      guard_reg <= ccde_pkg::GUARD_CLEAR;
    end else if (presc_reg == PRE_LAST) begin
      presc_reg <= PRE_ZERO;
      guard_reg <= guard_reg + 8'h01;
    end else begin
      presc_reg <= presc_reg + PRE_W'(1);
    end
  end

  // Status flags: restart sets both, hardware events clear
  always_ff @(posedge core_clk) begin
    if (reset || is_guard) begin
      expiry_n_reg <= ccde_pkg::FLAG_N_RESET;
      sleep_n_reg <= ccde_pkg::FLAG_N_RESET;
    end else begin
      if (presc_reg == PRE_LAST && guard_reg == ccde_pkg::GUARD_LAST) begin
        expiry_n_reg <= 1'b0;
      end
      if (sleep_enter) begin
        sleep_n_reg <= 1'b0;
      end
    end
  end

  // ========================================================
  // Outputs
  // ========================================================
  assign pc = pc_reg;
  assign stack_push = push_reg;
  assign stack_top = push_data_reg;
  assign acc = acc_reg;
  assign null_flag = null_reg;
  assign file_wr_en = wr_en_reg;
  assign file_wr_addr = wr_addr_reg;
  assign file_wr_data = wr_data_reg;
  assign discard = state_reg[1];
  assign expiry_flag_n = expiry_n_reg;
  assign sleep_flag_n = sleep_n_reg;
  assign guard_timer_count = guard_reg;
  assign icyc_en = icyc_en_reg;

  // ========================================================
  // Assertions
  // ========================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Accepted op of a given kind
  sequence s_take(logic [3:0] c);
    take && (op_code == c);
  endsequence

  // Discard held for three core clocks, with no cycle pulse in the last two
  sequence s_discard_cycle;
    discard ##1 (discard && !icyc_en_reg)[*2];
  endsequence

  a_call_push: assert property (
    s_take(ccde_pkg::OP_CALL_IMM) |=> stack_push &&
      stack_top == $past(pc_reg) + ccde_pkg::PC_STEP)
    else $error("immediate call pushed wrong return");

  a_call_target: assert property (
    s_take(ccde_pkg::OP_CALL_IMM) |=>
      pc == {$past(upper_pc_latch[6:3]), $past(op_lit)})
    else $error("immediate call target wrong");

  a_call_two_cycles: assert property (
    s_take(ccde_pkg::OP_CALL_IMM) |=> s_discard_cycle)
    else $error("immediate call not two cycles");

  a_acall_push: assert property (
    s_take(ccde_pkg::OP_CALL_ACC) |=> stack_push &&
      stack_top == $past(pc_reg) + ccde_pkg::PC_STEP)
    else $error("accumulator call pushed wrong return");

  a_acall_target: assert property (
    s_take(ccde_pkg::OP_CALL_ACC) |=>
      pc == {$past(upper_pc_latch), $past(acc_reg)})
    else $error("accumulator call target wrong");

  a_acall_cycles: assert property (
    s_take(ccde_pkg::OP_CALL_ACC) |=> discard ##[1:8] !discard)
    else $error("accumulator call length wrong");

  a_guard_clear: assert property (
    s_take(ccde_pkg::OP_GUARD) |=> guard_timer_count == 8'h00 &&
      presc_reg == PRE_ZERO)
    else $error("guard restart did not clear");

  a_guard_flags: assert property (
    s_take(ccde_pkg::OP_GUARD) |=> expiry_flag_n && sleep_flag_n)
    else $error("guard restart flags not set");

  a_comp_file: assert property (
    take && op_code == ccde_pkg::OP_COMPLEMENT && op_dest |=>
      file_wr_en &&
      file_wr_data == ~$past(file_rd_data))
    else $error("complement to file wrong");

  a_dest_acc: assert property (
    take && is_fileop && !op_dest |=> !file_wr_en &&
      acc == $past(alu_result))
    else $error("accumulator destination wrong");

  a_clear_file: assert property (
    s_take(ccde_pkg::OP_CLEAR_FILE) |=> file_wr_en &&
      file_wr_data == 8'h00 && file_wr_addr == $past(op_file) &&
      null_flag)
    else $error("clear file wrong");

  a_clear_acc: assert property (
    s_take(ccde_pkg::OP_CLEAR_ACC) |=> acc == 8'h00 && null_flag)
    else $error("clear accumulator wrong");

  a_dec_value: assert property (
    take && op_code == ccde_pkg::OP_DECREMENT && !op_dest |=>
      acc == $past(file_rd_data) - 8'h01 &&
      null_flag == ($past(file_rd_data) == 8'h01))
    else $error("decrement wrong");

  a_skip_zero: assert property (
    take && op_code == ccde_pkg::OP_DEC_SKIP &&
      file_rd_data == 8'h01 |=>
      discard && pc == $past(pc_reg) + ccde_pkg::PC_SKIP_STEP)
    else $error("skip on zero not taken");

  a_skip_nop: assert property (
    discard && icyc_en_reg |=> !discard && $stable(pc) &&
      !stack_push && !file_wr_en && $stable(acc))
    else $error("discarded op had an effect");

  a_null_keep: assert property (
    s_take(ccde_pkg::OP_DEC_SKIP) |=> $stable(null_flag))
    else $error("decrement-skip changed null flag");

  a_single_step: assert property (
    s_take(ccde_pkg::OP_COMPLEMENT) |=> !discard &&
      pc == $past(pc_reg) + ccde_pkg::PC_STEP)
    else $error("single-cycle op wrong pc");

endmodule

//--- bench/call_clear_decrement_exec_test.sv
`timescale 1ns/1ns
// ==========================================================
// Comparison helper, counts every compare and every mismatch
// ==========================================================
`define CHK(nm, ex, got) begin \
  checks++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); \
  end \
end

module call_clear_decrement_exec_test;
  // ========================================================
  // Stimulus and observed signals
  // ========================================================
  logic core_clk = 1'b0;   // 125 MHz core clock
  logic reset = 1'b1;      // Synchronous, active high
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [10:0] op_lit = 11'h000;
  logic [6:0] op_file = 7'h00;
  logic op_dest = 1'b0;
  logic [7:0] file_rd_data = 8'h00;
  logic [6:0] upper_pc_latch = 7'h00;
  logic sleep_enter = 1'b0;
  logic [14:0] pc, stack_top;
  logic stack_push, null_flag, file_wr_en, discard, icyc_en;
  logic expiry_flag_n, sleep_flag_n;
  logic [7:0] acc, file_wr_data, guard_timer_count;
  logic [6:0] file_wr_addr;
  // Bench's own copy of the architectural state
  logic [14:0] exp_pc = 15'h0000;
  logic [7:0] exp_acc = 8'h00;
  logic exp_null = 1'b0;
  int error_cnt = 0;
  int checks = 0;
  int n;

  // Small prescaler so the guard timer expires within a short run
  ccde_exec #(.ICYC_CLKS(4), .GUARD_PRESC(2)) u_dut (
    .core_clk(core_clk), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .op_lit(op_lit), .op_file(op_file),
    .op_dest(op_dest), .file_rd_data(file_rd_data),
    .upper_pc_latch(upper_pc_latch), .sleep_enter(sleep_enter),
    .pc(pc), .stack_push(stack_push), .stack_top(stack_top),
    .acc(acc), .null_flag(null_flag), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .discard(discard), .expiry_flag_n(expiry_flag_n),
    .sleep_flag_n(sleep_flag_n),
    .guard_timer_count(guard_timer_count), .icyc_en(icyc_en)
  );

  // Clock generator, half period 4 ns
  initial begin
    forever #4 core_clk = ~core_clk;
  end

  // ========================================================
  // Tasks
  // ========================================================
  // Closing report, the only place the run ends
  task automatic print_verdict;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A bounded wait that ran out counts as a mismatch
  task automatic timed_out(input string what);
    error_cnt++;
    $display("[ERR] %s expected event seen none", what);
    print_verdict;
  endtask

  // Present one op, wait for its slot, stop where results settle
  task automatic do_op(input ccde_pkg::ccde_op_t op,
                       input logic [10:0] lit, input logic [6:0] fa,
                       input logic d, input logic [7:0] rd);
    int k;
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= op;
    op_lit <= lit;
    op_file <= fa;
    op_dest <= d;
    file_rd_data <= rd;
    // Slot is open when the strobe is up and no discard runs
    for (k = 0; k < 20; k++) begin
      @(negedge core_clk);
      if (icyc_en === 1'b1 && discard === 1'b0) break;
    end
    if (k == 20) timed_out("op slot");
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Single-cycle completion: next address, no discard, no push
  task automatic chk_one;
    `CHK("pc", exp_pc, pc)
    `CHK("discard", 1'b0, discard)
    `CHK("stack_push", 1'b0, stack_push)
  endtask

  // Discarded slot lasts one full instruction cycle, then ends
  task automatic chk_two;
    int k;
    for (k = 0; k < 3; k++) begin
      @(negedge core_clk);
      `CHK("discard", 1'b1, discard)
      `CHK("stack_push", 1'b0, stack_push)
    end
    @(negedge core_clk);
    `CHK("discard", 1'b0, discard)
  endtask

  // Either call form; a clear-acc parked in the dead slot must die
  task automatic do_call(input ccde_pkg::ccde_op_t op,
                         input logic [10:0] lit, input logic [6:0] lat,
                         input logic [14:0] tgt);
    logic [14:0] ret;
    ret = exp_pc + 15'h0001;
    @(posedge core_clk);
    upper_pc_latch <= lat;
    do_op(op, lit, 7'h00, 1'b0, 8'h00);
    exp_pc = tgt;
    `CHK("stack_push", 1'b1, stack_push)
    `CHK("stack_top", ret, stack_top)
    `CHK("pc", exp_pc, pc)
    `CHK("discard", 1'b1, discard)
    @(posedge core_clk);
    op_code <= ccde_pkg::OP_CLEAR_ACC;
    chk_two;
    `CHK("acc", exp_acc, acc)
    `CHK("pc", exp_pc, pc)
    `CHK("null", exp_null, null_flag)
  endtask

  // Result of a file op: accumulator or a file write pulse
  task automatic chk_dest(input logic d, input logic [6:0] fa,
                          input logic [7:0] res);
    if (d == 1'b0) begin
      exp_acc = res;
    end
    `CHK("acc", exp_acc, acc)
    `CHK("file_wr_en", d, file_wr_en)
    if (d == 1'b1) begin
      `CHK("file_wr_addr", fa, file_wr_addr)
      `CHK("file_wr_data", res, file_wr_data)
    end
    `CHK("null", exp_null, null_flag)
  endtask

  // ========================================================
  // Main sequence
  // ========================================================
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    // Complement into the accumulator, non-zero result
    do_op(ccde_pkg::OP_COMPLEMENT, 11'h000, 7'h10, 1'b0, 8'h5A);
    exp_pc = exp_pc + 15'h0001;
    chk_dest(1'b0, 7'h10, 8'hA5);
    chk_one;
    // Accumulator call: full latch on top, accumulator below
    do_call(ccde_pkg::OP_CALL_ACC, 11'h000, 7'h55, 15'h55A5);
    // Immediate call: operand at its top value, latch bits 6:3
    do_call(ccde_pkg::OP_CALL_IMM, 11'h7FF, 7'h2C, 15'h2FFF);
    // Complement written back, zero result sets the flag
    do_op(ccde_pkg::OP_COMPLEMENT, 11'h000, 7'h7F, 1'b1, 8'hFF);
    exp_pc = exp_pc + 15'h0001;
    exp_null = 1'b1;
    chk_dest(1'b1, 7'h7F, 8'h00);
    chk_one;
    // Decrement wraps from zero, flag clears
    do_op(ccde_pkg::OP_DECREMENT, 11'h000, 7'h01, 1'b0, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    exp_null = 1'b0;
    chk_dest(1'b0, 7'h01, 8'hFF);
    chk_one;
    // Clear accumulator sets the flag
    do_op(ccde_pkg::OP_CLEAR_ACC, 11'h000, 7'h00, 1'b0, 8'h33);
    exp_pc = exp_pc + 15'h0001;
    exp_null = 1'b1;
    chk_dest(1'b0, 7'h00, 8'h00);
    chk_one;
    // Decrement back to file, non-zero clears the flag
    do_op(ccde_pkg::OP_DECREMENT, 11'h000, 7'h22, 1'b1, 8'h05);
    exp_pc = exp_pc + 15'h0001;
    exp_null = 1'b0;
    chk_dest(1'b1, 7'h22, 8'h04);
    chk_one;
    // Decrement-skip reaching zero: skip taken, flag kept
    do_op(ccde_pkg::OP_DEC_SKIP, 11'h000, 7'h40, 1'b1, 8'h01);
    exp_pc = exp_pc + 15'h0002;
    chk_dest(1'b1, 7'h40, 8'h00);
    `CHK("pc", exp_pc, pc)
    `CHK("discard", 1'b1, discard)
    chk_two;
    // Clear file at the highest address sets the flag
    do_op(ccde_pkg::OP_CLEAR_FILE, 11'h000, 7'h7F, 1'b1, 8'hC3);
    exp_pc = exp_pc + 15'h0001;
    exp_null = 1'b1;
    chk_dest(1'b1, 7'h7F, 8'h00);
    chk_one;
    // Decrement-skip not reaching zero: no skip, flag kept
    do_op(ccde_pkg::OP_DEC_SKIP, 11'h000, 7'h05, 1'b0, 8'h02);
    exp_pc = exp_pc + 15'h0001;
    chk_dest(1'b0, 7'h05, 8'h01);
    chk_one;
    // Sleep entry, then let the guard timer run out
    @(posedge core_clk);
    op_valid <= 1'b0;
    sleep_enter <= 1'b1;
    @(posedge core_clk);
    sleep_enter <= 1'b0;
    @(negedge core_clk);
    `CHK("sleep_flag_n", 1'b0, sleep_flag_n)
    for (n = 0; n < 1000; n++) begin
      @(negedge core_clk);
      if (expiry_flag_n === 1'b0) break;
    end
    if (n == 1000) timed_out("guard expiry");
    // Restart: count, prescaler and both flags back to idle
    do_op(ccde_pkg::OP_GUARD, 11'h000, 7'h00, 1'b0, 8'h00);
    exp_pc = exp_pc + 15'h0001;
    `CHK("guard_count", 8'h00, guard_timer_count)
    `CHK("expiry_flag_n", 1'b1, expiry_flag_n)
    `CHK("sleep_flag_n", 1'b1, sleep_flag_n)
    `CHK("null", exp_null, null_flag)
    chk_one;
    // A stale prescaler would tick the count one clock later
    @(negedge core_clk);
    `CHK("guard_count", 8'h00, guard_timer_count)
    print_verdict;
  end
endmodule
